// ==== logger_modem_pkg.sv ====
// Purpose: Shared constants and types for the logger-side modem port.
// Assumes: One 40 MHz reference clock; logger pins are asynchronous.
// Notes: Timing counts derive from the clock rate and the link rates.
`default_nettype none

package logger_modem_pkg;

    // Reference clock and link rates
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD_DEFAULT = 3000;
    localparam int BAUD_LEGACY = 2400;
    localparam int BIT_CYCLES_DEFAULT = CLK_HZ / BAUD_DEFAULT;
    localparam int BIT_CYCLES_LEGACY = CLK_HZ / BAUD_LEGACY;
    localparam int RATE_CNT_W = 15;

    // Address shifted in from the logger
    localparam int ADDR_BITS = 8;
    localparam int ADDR_CNT_W = 3;
    localparam logic [2:0] ADDR_LAST_BIT = 3'h7;
    localparam int ADDR_CONNECT_BIT = 7;
    localparam logic [7:0] ADDR_RESET = 8'h00;

    // Synchronised logger pins, in bus order
    localparam int PIN_COUNT = 4;
    localparam int PIN_HOST_EN = 0;
    localparam int PIN_SHIFT_CLK = 1;
    localparam int PIN_SELECT = 2;
    localparam int PIN_TXD = 3;
    localparam logic [3:0] PIN_RESET = 4'h8; // Idle pins: enable low, data line high

    // Single-letter commands, ASCII
    localparam logic [7:0] CHAR_SETUP = 8'h53;
    localparam logic [7:0] CHAR_CMD_R = 8'h52;
    localparam logic [7:0] CHAR_CMD_T = 8'h54;
    localparam logic [7:0] CHAR_CMD_F = 8'h46;
    localparam logic [7:0] CHAR_OLD_LINK = 8'h55;
    localparam int CMD_COUNT = 5;
    localparam int CMD_SETUP = 0;
    localparam int CMD_R = 1;
    localparam int CMD_T = 2;
    localparam int CMD_F = 3;
    localparam int CMD_OLD_LINK = 4;

    // Synchronous-device session states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_ACTIVE = 2'b10
    } sync_state_e;

endpackage

`default_nettype wire

// ==== pin_sync_if.sv ====
// Purpose: Carries raw logger pins to the synchroniser and clean levels back.
// Assumes: Raw side is asynchronous to the reference clock.
// Notes: Bit order follows the PIN_ indices of the package.
`default_nettype none

interface pin_sync_if;
    import logger_modem_pkg::*;

    logic [PIN_COUNT-1:0] raw;
    logic [PIN_COUNT-1:0] clean;

    // Synchroniser end and user end
    modport sync_side (input raw, output clean);
    modport user_side (output raw, input clean);
endinterface

`default_nettype wire

// ==== pin_synchronizer.sv ====
// Purpose: Three-stage synchroniser with agreement filter per logger pin.
// Assumes: Pins change slowly relative to the reference clock.
// Notes: A change counts once stages two and three agree.
`default_nettype none

module pin_synchronizer
    import logger_modem_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Pins in, clean levels out
    pin_sync_if.sync_side pins
);

    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic level_reg;

            // Three flops; only the second reads the first
            always_ff @(posedge i_ref_clk) begin
                if (i_srst) begin
                    s1_reg <= PIN_RESET[g];
                    s2_reg <= PIN_RESET[g];
                    s3_reg <= PIN_RESET[g];
                end else begin
                    s1_reg <= pins.raw[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end

            // Accept a level once the last two stages agree
            always_ff @(posedge i_ref_clk) begin
                if (i_srst) begin
                    level_reg <= PIN_RESET[g];
                end else if (s2_reg == s3_reg) begin
                    level_reg <= s3_reg;
                end
            end

            assign pins.clean[g] = level_reg;
        end
    endgenerate

endmodule

`default_nettype wire

// ==== rate_tick_gen.sv ====
// Purpose: Bit-rate enable pulse for the radio link.
// Assumes: Period counts fit RATE_CNT_W bits.
// Notes: A rate change restarts the count from zero.
`default_nettype none

module rate_tick_gen
    import logger_modem_pkg::*;
#(
    parameter int CYCLES_DEFAULT = BIT_CYCLES_DEFAULT,
    parameter int CYCLES_LEGACY = BIT_CYCLES_LEGACY
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Rate select and enable out
    input wire logic i_legacy,
    output logic o_tick
);

    localparam logic [RATE_CNT_W-1:0] LAST_DEFAULT = RATE_CNT_W'(CYCLES_DEFAULT - 1);
    localparam logic [RATE_CNT_W-1:0] LAST_LEGACY = RATE_CNT_W'(CYCLES_LEGACY - 1);

    logic [RATE_CNT_W-1:0] cnt_reg;
    logic legacy_reg;
    logic tick_reg;
    logic [RATE_CNT_W-1:0] last;

    assign last = legacy_reg ? LAST_LEGACY : LAST_DEFAULT;

    // Period counter, one pulse per bit time
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cnt_reg <= '0;
            legacy_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            legacy_reg <= i_legacy;
            tick_reg <= 1'b0;
            if (legacy_reg != i_legacy || cnt_reg == last) begin
                cnt_reg <= '0;
                tick_reg <= (cnt_reg == last);
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    assign o_tick = tick_reg;

endmodule

`default_nettype wire

// ==== logger_modem_sync_address_port.sv ====
// Purpose: Logger-side port of a telemetry modem: ring, enable, address, gating.
// Assumes: Logger drives the shift clock; commands arrive already decoded to chars.
// Notes: Mode strap is static; select low ends a synchronous session.
`default_nettype none

// How it works
// - One static mode: host-enable or synchronous-device
// - Ring logger until host enable goes high
// - Host enable high: transparent or far-end mode
// - Addressing request drops ring, starts address
// - Sample on clock rise; done at bit eight
// - Connect command in address swaps data lines
// - Active: receiver on when select, clock high
// - Active: transmitter on when select high, clock low
// - Active: only the five letter commands act
// - Old-link before path gives 2400, else 3000
// - Remote answers detected legacy rate at that rate
module logger_modem_sync_address_port
    import logger_modem_pkg::*;
#(
    parameter int CYCLES_DEFAULT = BIT_CYCLES_DEFAULT,
    parameter int CYCLES_LEGACY = BIT_CYCLES_LEGACY
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Static configuration
    input wire logic i_sync_select_state,
    input wire logic i_far_end_position,
    // Logger pins
    input wire logic i_host_enable_line,
    input wire logic i_shift_clock_handshake,
    input wire logic i_device_select_line,
    input wire logic i_txd,
    output logic o_ring,
    output logic o_logger_rxd,
    // Modem side
    input wire logic i_ring_request,
    input wire logic i_radio_rx_data,
    input wire logic i_store_rx_data,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_char,
    input wire logic i_path_start,
    input wire logic i_legacy_detected,
    output logic o_radio_tx_data,
    output logic o_store_tx_data,
    output logic o_transparent_mode,
    output logic o_far_end_mode,
    output logic [7:0] o_address,
    output logic o_address_valid,
    output logic o_swap_lines,
    output logic o_rx_enable,
    output logic o_tx_enable,
    output logic [CMD_COUNT-1:0] o_cmd_strobe,
    output logic o_legacy_rate,
    output logic o_bit_tick
);

    pin_sync_if pins ();

    sync_state_e state_reg;
    logic ring_reg;
    logic clk_prev_reg;
    logic [ADDR_CNT_W-1:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic addr_valid_reg;
    logic swap_reg;
    logic transparent_reg;
    logic far_end_reg;
    logic rx_en_reg;
    logic tx_en_reg;
    logic [CMD_COUNT-1:0] cmd_reg;
    logic old_link_pending_reg;
    logic legacy_reg;
    logic logger_rxd_reg;
    logic radio_txd_reg;
    logic store_txd_reg;
    logic hen;
    logic sclk;
    logic sel;
    logic txd;
    logic clk_rise;
    logic addr_request;
    logic cmd_window;
    logic [CMD_COUNT-1:0] cmd_hit;

    // Raw pins into the synchroniser
    assign pins.raw[PIN_HOST_EN] = i_host_enable_line;
    assign pins.raw[PIN_SHIFT_CLK] = i_shift_clock_handshake;
    assign pins.raw[PIN_SELECT] = i_device_select_line;
    assign pins.raw[PIN_TXD] = i_txd;

    pin_synchronizer u_sync (
        .i_ref_clk (i_ref_clk),
        .i_srst (i_srst),
        .pins (pins.sync_side)
    );

    assign hen = pins.clean[PIN_HOST_EN];
    assign sclk = pins.clean[PIN_SHIFT_CLK];
    assign sel = pins.clean[PIN_SELECT];
    assign txd = pins.clean[PIN_TXD];
    assign clk_rise = sclk && !clk_prev_reg;
    assign addr_request = i_sync_select_state && sel && sclk;

    // Shift clock edge finder on the clean level
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= sclk;
        end
    end

    // Session state machine of the synchronous-device mode
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !i_sync_select_state) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (addr_request) begin
                        state_reg <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (!sel) begin
                        state_reg <= ST_IDLE;
                    end else if (clk_rise && bit_cnt_reg == ADDR_LAST_BIT) begin
                        state_reg <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (!sel) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Address shifter, LSB arrives first
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            bit_cnt_reg <= '0;
            shift_reg <= ADDR_RESET;
            addr_valid_reg <= 1'b0;
            swap_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            bit_cnt_reg <= '0;
            addr_valid_reg <= 1'b0;
            swap_reg <= 1'b0;
        end else if (state_reg == ST_ADDR && sel && clk_rise) begin
            shift_reg <= {txd, shift_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == ADDR_LAST_BIT) begin
                addr_valid_reg <= 1'b1;
                swap_reg <= txd;
            end
        end
    end

    // Ring line toward the logger
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ring_reg <= 1'b0;
        end else if (i_sync_select_state) begin
            if (state_reg != ST_IDLE || addr_request) begin
                ring_reg <= 1'b0;
            end else if (i_ring_request) begin
                ring_reg <= 1'b1;
            end
        end else if (hen) begin
            ring_reg <= 1'b0;
        end else if (i_ring_request) begin
            ring_reg <= 1'b1;
        end
    end

    // Host-enable mode: pass-through or far-end by link position
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            transparent_reg <= 1'b0;
            far_end_reg <= 1'b0;
        end else begin
            transparent_reg <= !i_sync_select_state && hen && !i_far_end_position;
            far_end_reg <= !i_sync_select_state && hen && i_far_end_position;
        end
    end

    // Radio gating while a session is active
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rx_en_reg <= 1'b0;
            tx_en_reg <= 1'b0;
        end else if (!sel || state_reg != ST_ACTIVE) begin
            rx_en_reg <= 1'b0;
            tx_en_reg <= 1'b0;
        end else begin
            rx_en_reg <= sclk;
            tx_en_reg <= !sclk;
        end
    end

    // Command decoder, only the five letters act
    assign cmd_window = i_sync_select_state ? (state_reg == ST_ACTIVE) : hen;
    assign cmd_hit[CMD_SETUP] = (i_cmd_char == CHAR_SETUP);
    assign cmd_hit[CMD_R] = (i_cmd_char == CHAR_CMD_R);
    assign cmd_hit[CMD_T] = (i_cmd_char == CHAR_CMD_T);
    assign cmd_hit[CMD_F] = (i_cmd_char == CHAR_CMD_F);
    assign cmd_hit[CMD_OLD_LINK] = (i_cmd_char == CHAR_OLD_LINK);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cmd_reg <= '0;
        end else if (i_cmd_valid && cmd_window) begin
            cmd_reg <= cmd_hit;
        end else begin
            cmd_reg <= '0;
        end
    end

    // Old-link request waits for the next path setup string
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            old_link_pending_reg <= 1'b0;
        end else if (i_cmd_valid && cmd_window && cmd_hit[CMD_OLD_LINK]) begin
            old_link_pending_reg <= 1'b1; // Set wins over the path-start clear
        end else if (i_path_start) begin
            old_link_pending_reg <= 1'b0;
        end
    end

    // Link rate: legacy on old-link path or detected legacy caller
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            legacy_reg <= 1'b0;
        end else if (i_legacy_detected) begin
            legacy_reg <= 1'b1;
        end else if (i_path_start) begin
            legacy_reg <= old_link_pending_reg;
        end
    end

    rate_tick_gen #(
        .CYCLES_DEFAULT (CYCLES_DEFAULT),
        .CYCLES_LEGACY (CYCLES_LEGACY)
    ) u_rate (
        .i_ref_clk (i_ref_clk),
        .i_srst (i_srst),
        .i_legacy (legacy_reg),
        .o_tick (o_bit_tick)
    );

    // Data routing, swapped through the storage module on connect
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            logger_rxd_reg <= 1'b1;
            radio_txd_reg <= 1'b1;
            store_txd_reg <= 1'b1;
        end else begin
            logger_rxd_reg <= swap_reg ? i_store_rx_data : i_radio_rx_data;
            radio_txd_reg <= swap_reg ? 1'b1 : txd;
            store_txd_reg <= swap_reg ? txd : 1'b1;
        end
    end

    assign o_ring = ring_reg;
    assign o_logger_rxd = logger_rxd_reg;
    assign o_radio_tx_data = radio_txd_reg;
    assign o_store_tx_data = store_txd_reg;
    assign o_transparent_mode = transparent_reg;
    assign o_far_end_mode = far_end_reg;
    assign o_address = shift_reg;
    assign o_address_valid = addr_valid_reg;
    assign o_swap_lines = swap_reg;
    assign o_rx_enable = rx_en_reg;
    assign o_tx_enable = tx_en_reg;
    assign o_cmd_strobe = cmd_reg;
    assign o_legacy_rate = legacy_reg;

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    mode_exclusive_a: assert property (i_sync_select_state && $past(i_sync_select_state)
        |-> !o_transparent_mode && !o_far_end_mode)
        else $error("host-enable mode output in synchronous mode");
    ring_hold_a: assert property (!i_sync_select_state && o_ring && !hen |=> o_ring)
        else $error("ring dropped before host enable");
    host_mode_a: assert property (!i_sync_select_state && hen |=>
        (o_far_end_mode == i_far_end_position) && (o_transparent_mode != o_far_end_mode))
        else $error("wrong host-enable mode");
    ring_drop_a: assert property (state_reg == ST_IDLE && addr_request
        |=> state_reg == ST_ADDR && !o_ring)
        else $error("addressing request not taken");
    addr_done_a: assert property (state_reg == ST_ADDR && sel && clk_rise
        && bit_cnt_reg == ADDR_LAST_BIT |=> state_reg == ST_ACTIVE && o_address_valid)
        else $error("address not complete at eighth bit");
    swap_lines_a: assert property ($rose(state_reg == ST_ACTIVE)
        |-> o_swap_lines == o_address[ADDR_CONNECT_BIT])
        else $error("line swap disagrees with address");
    rx_gate_a: assert property (state_reg == ST_ACTIVE && sel && sclk
        |=> o_rx_enable && !o_tx_enable)
        else $error("receiver not enabled");
    tx_gate_a: assert property (state_reg == ST_ACTIVE && sel && !sclk
        |=> o_tx_enable && !o_rx_enable)
        else $error("transmitter not enabled");
    cmd_filter_a: assert property (i_cmd_valid && (!cmd_window || cmd_hit == '0)
        |=> o_cmd_strobe == '0)
        else $error("unknown command acted on");
    rate_path_a: assert property (i_path_start && !i_legacy_detected
        |=> o_legacy_rate == $past(old_link_pending_reg))
        else $error("link rate not set by path start");
    rate_detect_a: assert property (i_legacy_detected |=> o_legacy_rate)
        else $error("detected legacy rate not kept");
    select_low_a: assert property (i_sync_select_state && !sel ##1 !sel
        |-> !o_rx_enable && !o_tx_enable)
        else $error("radio enabled with select low");

    addr_seen_c: cover property (state_reg == ST_ADDR ##[1:1000] state_reg == ST_ACTIVE);
    swap_seen_c: cover property (state_reg == ST_ACTIVE && o_swap_lines);
    legacy_seen_c: cover property (o_cmd_strobe[CMD_OLD_LINK] ##[1:100] o_legacy_rate);
    ring_seen_c: cover property (o_ring ##[1:1000] o_transparent_mode);

endmodule

`default_nettype wire

// ==== logger_sync_ctrl_model.sv ====
// Purpose: Behavioural logger acting as synchronous device controller.
// Assumes: Shift clock of 200 ns period, also made outside frames by stray_edges.
// Notes: Data line shows the inverse of the last bit once an address is over.
`default_nettype none

module logger_sync_ctrl_model (
    // Logger pins toward the modem
    output var logic o_host_enable_line,
    output var logic o_shift_clock_handshake,
    output var logic o_device_select_line,
    output var logic o_txd
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam time HALF = 100ns;

    // Idle pins: clock stands low, not selected
    initial begin
        o_host_enable_line = 1'b0;
        o_shift_clock_handshake = 1'b0;
        o_device_select_line = 1'b0;
        o_txd = 1'b1;
    end

    // Enable line after the logger has settled its rate and prompt
    task automatic set_host_enable(input logic lvl);
        #13ns;
        o_host_enable_line = lvl;
    endtask

    // Addressing request: clock first, then select
    task automatic begin_session();
        o_shift_clock_handshake = 1'b1;
        #HALF;
        o_device_select_line = 1'b1;
        #HALF;
    endtask

    // Eight bits, low bit first, each presented before the rising edge
    task automatic send_address(input logic [7:0] addr);
        for (int i = 0; i < 8; i++) begin
            o_shift_clock_handshake = 1'b0;
            o_txd = addr[i];
            #HALF;
            o_shift_clock_handshake = 1'b1;
            #HALF;
        end
        o_txd = ~addr[7]; // Released line does not hold the last bit
    endtask

    // Levels used for gating in the active state
    task automatic set_clock(input logic lvl);
        o_shift_clock_handshake = lvl;
    endtask

    task automatic set_txd(input logic lvl);
        o_txd = lvl;
    endtask

    // Deselect, then park the clock
    task automatic end_session();
        o_device_select_line = 1'b0;
        #HALF;
        o_shift_clock_handshake = 1'b0;
    endtask

    // Clock edges while not selected
    task automatic stray_edges(input int n);
        for (int i = 0; i < n; i++) begin
            o_shift_clock_handshake = 1'b1;
            #HALF;
            o_shift_clock_handshake = 1'b0;
            #HALF;
        end
    endtask
endmodule

`default_nettype wire

// ==== logger_modem_sync_address_port_test.sv ====
// Purpose: Self-checking bench for the logger-side modem port.
// Assumes: Shortened bit periods of 10 and 13 clocks.
// Notes: Pin changes are given eight clocks to cross the synchroniser.
`default_nettype none

module logger_modem_sync_address_port_test
    import logger_modem_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int CYC_DEF = 10;
    localparam int CYC_LEG = 13;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic sync_mode = 1'b0;
    logic far_end = 1'b0;
    logic ring_req = 1'b0;
    logic radio_rx = 1'b0;
    logic store_rx = 1'b1;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_char = 8'h00;
    logic path_start = 1'b0;
    logic legacy_det = 1'b0;
    wire logic host_en, sclk, sel, txd;
    logic ring, logger_rxd, radio_tx, store_tx, transp, far_mode;
    logic addr_valid, swap, rx_en, tx_en, legacy, tick;
    logic [7:0] addr;
    logic [CMD_COUNT-1:0] strobe;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    logger_sync_ctrl_model partner_u (.o_host_enable_line(host_en),
        .o_shift_clock_handshake(sclk), .o_device_select_line(sel), .o_txd(txd));

    logger_modem_sync_address_port #(.CYCLES_DEFAULT(CYC_DEF), .CYCLES_LEGACY(CYC_LEG)) dut_u (
        .i_ref_clk(ref_clk), .i_srst(srst), .i_sync_select_state(sync_mode),
        .i_far_end_position(far_end), .i_host_enable_line(host_en),
        .i_shift_clock_handshake(sclk), .i_device_select_line(sel), .i_txd(txd),
        .o_ring(ring), .o_logger_rxd(logger_rxd), .i_ring_request(ring_req),
        .i_radio_rx_data(radio_rx), .i_store_rx_data(store_rx), .i_cmd_valid(cmd_valid),
        .i_cmd_char(cmd_char), .i_path_start(path_start), .i_legacy_detected(legacy_det),
        .o_radio_tx_data(radio_tx), .o_store_tx_data(store_tx), .o_transparent_mode(transp),
        .o_far_end_mode(far_mode), .o_address(addr), .o_address_valid(addr_valid),
        .o_swap_lines(swap), .o_rx_enable(rx_en), .o_tx_enable(tx_en),
        .o_cmd_strobe(strobe), .o_legacy_rate(legacy), .o_bit_tick(tick));

    // 40 MHz reference clock
    initial begin
        forever #12.5ns ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            close_out();
        end
    end

    task automatic close_out();
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2ns;
    endtask

    // Reset with the strap set beforehand, pins given time to settle
    task automatic restart(input logic mode, input logic far);
        cyc(1);
        srst = 1'b1;
        sync_mode = mode;
        far_end = far;
        cyc(6);
        srst = 1'b0;
        cyc(8);
    endtask

    task automatic ring_once();
        ring_req = 1'b1;
        cyc(1);
        ring_req = 1'b0;
        cyc(1);
    endtask

    // Ringing persists until enable, then the position picks the mode
    task automatic host_scenario(input logic far);
        restart(1'b0, far);
        ring_once();
        partner_u.begin_session();
        cyc(8);
        check("ring held", 8'h01, {7'h0, ring});
        partner_u.end_session();
        partner_u.set_host_enable(1'b1);
        cyc(8);
        check("ring after enable", 8'h00, {7'h0, ring});
        check("mode pair", {6'h0, ~far, far}, {6'h0, transp, far_mode});
        partner_u.set_host_enable(1'b0);
    endtask

    task automatic send_cmd(input logic [7:0] c, input logic [4:0] exp);
        cmd_valid = 1'b1;
        cmd_char = c;
        cyc(1);
        cmd_valid = 1'b0;
        check("command strobe", {3'h0, exp}, {3'h0, strobe});
        cyc(1);
        check("strobe width", 8'h00, {3'h0, strobe});
    endtask

    task automatic pulse(input logic det);
        path_start = ~det;
        legacy_det = det;
        cyc(1);
        path_start = 1'b0;
        legacy_det = 1'b0;
        cyc(1);
    endtask

    task automatic tick_period(input int exp);
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (tick !== 1'b1 && n < 100);
        check("tick period", exp[7:0], n[7:0]);
    endtask

    // Address, gating, data routing and deselect for one session
    task automatic sync_session(input logic [7:0] a, input logic cmds);
        logic [7:0] chars [5];
        chars = '{CHAR_SETUP, CHAR_CMD_R, CHAR_CMD_T, CHAR_CMD_F, CHAR_OLD_LINK};
        ring_once();
        check("ring in idle", 8'h01, {7'h0, ring});
        send_cmd(CHAR_SETUP, 5'h00);
        partner_u.begin_session();
        cyc(8);
        check("ring dropped", 8'h00, {7'h0, ring});
        partner_u.send_address(a);
        cyc(8);
        check("address", a, addr);
        check("valid and swap", {6'h0, 1'b1, a[7]}, {6'h0, addr_valid, swap});
        check("sclk high gates", 8'h02, {6'h0, rx_en, tx_en});
        partner_u.set_clock(1'b0);
        partner_u.set_txd(1'b0);
        cyc(8);
        check("sclk low gates", 8'h01, {6'h0, rx_en, tx_en});
        check("data routing", {5'h0, a[7], ~a[7], a[7]},
              {5'h0, radio_tx, store_tx, logger_rxd});
        // Opposite levels on both receive sources show which one is routed
        radio_rx = 1'b1;
        store_rx = 1'b0;
        cyc(2);
        check("rxd routing", {7'h0, ~a[7]}, {7'h0, logger_rxd});
        radio_rx = 1'b0;
        store_rx = 1'b1;
        if (cmds) begin
            for (int i = 0; i < CMD_COUNT; i++) begin
                send_cmd(chars[i], 5'h01 << i);
            end
            send_cmd(8'h58, 5'h00);
            pulse(1'b0);
            check("legacy after old link", 8'h01, {7'h0, legacy});
            tick_period(CYC_LEG);
            pulse(1'b0);
            check("default without old link", 8'h00, {7'h0, legacy});
            pulse(1'b1);
            check("legacy detected", 8'h01, {7'h0, legacy});
        end
        partner_u.set_clock(1'b1);
        partner_u.end_session();
        cyc(8);
        check("deselect", 8'h00, {5'h0, addr_valid, rx_en, tx_en});
        partner_u.stray_edges(8);
        cyc(8);
        check("stray edges", 8'h00, {5'h0, addr_valid, rx_en, tx_en});
    endtask

    // Main sequence
    initial begin
        host_scenario(1'b0);
        host_scenario(1'b1);
        restart(1'b1, 1'b0);
        tick_period(CYC_DEF);
        sync_session(8'h8b, 1'b1);
        sync_session(8'h35, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
